// ===== logic/apc_pkg.sv
// shared constants for the alarm panel state controller
package apc_pkg;
   localparam int          CLK_HZ         = 200_000_000;
   localparam int          LINE_RESET_S   = 3;
   localparam int          CONFIRM_S      = 60;
   localparam int          FAULT_EXIT_S   = 8;
   localparam int          TEST_PERIOD_S  = 64;
   localparam int          BURST_PAUSE_S  = 1;
   localparam int          SLOW_FLASH_HZ  = 1;
   localparam int          FAST_FLASH_HZ  = 4;
   // one second tick and half-period counts for flashing
   localparam int          TICK_CYC       = CLK_HZ;
   localparam int          SLOW_HALF_CYC  = CLK_HZ / (2 * SLOW_FLASH_HZ);
   localparam int          FAST_HALF_CYC  = CLK_HZ / (2 * FAST_FLASH_HZ);
   // line classification codes
   localparam logic [1:0]  CLS_NORMAL     = 2'h0;
   localparam logic [1:0]  CLS_FIRE       = 2'h1;
   localparam logic [1:0]  CLS_SHORT      = 2'h2;
   localparam logic [1:0]  CLS_BREAK      = 2'h3;
   // line switch pair codes {first, second}
   localparam logic [1:0]  SW_DUTY        = 2'h0;
   localparam logic [1:0]  SW_TEST        = 2'h1;
   localparam logic [1:0]  SW_DISABLED    = 2'h2;
   localparam logic [1:0]  SW_DIRECT      = 2'h3;
   localparam logic        MODE_RESET_VAL = 1'b0;  // mode 1
   // per line sequence states
   typedef enum logic [2:0] {
      APC_LN_IDLE, APC_LN_RESET1, APC_LN_WAIT2, APC_LN_FIRE, APC_LN_RESETF
   } apc_line_t;
endpackage

// ===== logic/apc_ctrl.sv
// alarm panel supervisory state controller
`timescale 1ns/10ps
`default_nettype none

module apc_ctrl #(
   parameter int N_LINES    = 8,
   parameter int TICK_CYC   = apc_pkg::TICK_CYC,
   parameter int SLOW_HALF  = apc_pkg::SLOW_HALF_CYC,
   parameter int FAST_HALF  = apc_pkg::FAST_HALF_CYC
) (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_resetn,
   input  wire logic [2*N_LINES-1:0] i_line_class,
   input  wire logic [2*N_LINES-1:0] i_line_switch,
   input  wire logic [N_LINES-1:0]   i_line_removed,
   input  wire logic                 i_key_level2,
   input  wire logic                 i_btn_reset,
   input  wire logic                 i_btn_outputs,
   input  wire logic                 i_btn_buzzer,
   input  wire logic                 i_remote_fire_reset_input,
   input  wire logic [8:0]           i_fault_src,
   input  wire logic                 i_delay_set,
   input  wire logic                 i_mode_stored,
   output logic                      o_mode_store_we,
   output logic                      o_mode_store_val,
   output logic                      o_mode2,
   output logic [N_LINES-1:0]        o_line_power,
   output logic [N_LINES-1:0]        o_line_red,
   output logic [N_LINES-1:0]        o_line_yellow,
   output logic                      o_fire_state,
   output logic                      o_fault_state,
   output logic                      o_duty_mode,
   output logic                      o_led_power,
   output logic                      o_led_delay,
   output logic                      o_led_fire,
   output logic                      o_led_fault,
   output logic                      o_led_buzzer_silenced,
   output logic                      o_led_outputs_suppressed,
   output logic                      o_buzzer,
   output logic                      o_monitored_output_one,
   output logic                      o_monitored_output_two,
   output logic                      o_fire_relay_output,
   output logic                      o_fault_relay_output
);
   localparam int LW = $clog2(N_LINES > 1 ? N_LINES : 2);

   // two-stage synchronisers for all pin inputs except i_resetn and i_mode_stored
   logic [2*N_LINES-1:0] cls_s1, cls_s2, sw_s1, sw_s2;
   logic [N_LINES-1:0]   rem_s1, rem_s2;
   logic [14:0]          pin_s1, pin_s2;
   always_ff @(posedge i_clk_sys) begin
      cls_s1 <= i_line_class;
      cls_s2 <= cls_s1;
      sw_s1  <= i_line_switch;
      sw_s2  <= sw_s1;
      rem_s1 <= i_line_removed;
      rem_s2 <= rem_s1;
      pin_s1 <= {i_key_level2, i_btn_reset, i_btn_outputs, i_btn_buzzer,
                 i_remote_fire_reset_input, i_fault_src, i_delay_set};
      pin_s2 <= pin_s1;
   end
   logic       key2, b_rst, b_out, b_buz, rmt, dly;
   logic [8:0] fsrc;
   assign {key2, b_rst, b_out, b_buz, rmt, fsrc, dly} = pin_s2;

   // press edge detection on synchronised levels
   logic b_rst_d, b_out_d, b_buz_d, rmt_d;
   always_ff @(posedge i_clk_sys) begin
      b_rst_d <= b_rst;
      b_out_d <= b_out;
      b_buz_d <= b_buz;
      rmt_d   <= rmt;
   end
   logic sys_fault_reg;
   logic no_btn;
   assign no_btn = ~sys_fault_reg;
   logic p_rst, p_out, p_buz, p_rmt;
   assign p_rst = b_rst & ~b_rst_d & no_btn;
   assign p_out = b_out & ~b_out_d & no_btn;
   assign p_buz = b_buz & ~b_buz_d & no_btn;
   assign p_rmt = rmt & ~rmt_d;

   // one second tick and flash phases
   logic [31:0] tick_cnt, slow_cnt, fast_cnt;
   logic        tick, slow_ph, fast_ph;
   logic [5:0]  sec_cnt;                                      // free 64 s count
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         tick_cnt <= 32'h0;
         slow_cnt <= 32'h0;
         fast_cnt <= 32'h0;
         slow_ph  <= 1'b0;
         fast_ph  <= 1'b0;
         sec_cnt  <= 6'h0;
      end else begin
         tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
         slow_cnt <= (slow_cnt == 32'(SLOW_HALF - 1)) ? 32'h0 : slow_cnt + 32'h1;
         fast_cnt <= (fast_cnt == 32'(FAST_HALF - 1)) ? 32'h0 : fast_cnt + 32'h1;
         if (slow_cnt == 32'(SLOW_HALF - 1)) slow_ph <= ~slow_ph;
         if (fast_cnt == 32'(FAST_HALF - 1)) fast_ph <= ~fast_ph;
         if (tick) sec_cnt <= sec_cnt + 6'h1;
      end
   end
   assign tick = (tick_cnt == 32'(TICK_CYC - 1));

   // power-up mode capture after reset release
   logic mode_reg, boot_done;
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         mode_reg         <= apc_pkg::MODE_RESET_VAL;
         boot_done        <= 1'b0;
         o_mode_store_we  <= 1'b0;
         o_mode_store_val <= apc_pkg::MODE_RESET_VAL;
      end else begin
         o_mode_store_we <= 1'b0;
         if (!boot_done && tick_cnt == 32'h3) begin             // pins settled
            boot_done <= 1'b1;
            if (key2 && b_rst) begin
               mode_reg         <= ~i_mode_stored;
               o_mode_store_val <= ~i_mode_stored;
               o_mode_store_we  <= 1'b1;
            end else begin
               mode_reg <= i_mode_stored;
            end
         end
      end
   end
   assign o_mode2 = mode_reg;

   // remote input actions per mode
   logic remote_reset, remote_act;
   assign remote_reset = p_rmt & mode_reg & boot_done;
   assign remote_act   = p_rmt & ~mode_reg & boot_done;
   logic key_reset;
   assign key_reset = p_rst & key2 & boot_done;

   // round-robin scan pointer across lines
   logic [LW-1:0] scan_idx;
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn)
         scan_idx <= '0;
      else
         scan_idx <= (scan_idx == LW'(N_LINES - 1)) ? '0 : scan_idx + LW'(1);
   end

   // per-line double-activation sequence
   logic [N_LINES-1:0] ln_fire, ln_direct, ln_fault, ln_new_fire, ln_powered;
   logic [N_LINES-1:0] ln_test, ln_dis;
   genvar g;
   generate
      for (g = 0; g < N_LINES; g++) begin : gl
         apc_pkg::apc_line_t st;
         logic [5:0] secs;
         logic [1:0] cls, sw;
         logic       hit;
         assign cls = cls_s2[2*g+1:2*g];
         assign sw  = sw_s2[2*g+1:2*g];
         assign hit = (scan_idx == LW'(g)) && (cls == apc_pkg::CLS_FIRE);
         assign ln_test[g] = (sw == apc_pkg::SW_TEST);
         assign ln_dis[g]  = (sw == apc_pkg::SW_DISABLED);
         assign ln_fault[g] = ~ln_dis[g] & ~ln_test[g] &
                              ((cls == apc_pkg::CLS_SHORT) | (cls == apc_pkg::CLS_BREAK) |
                               rem_s2[g]);
         always_ff @(posedge i_clk_sys) begin
            ln_new_fire[g] <= 1'b0;
            if (!i_resetn) begin
               st           <= apc_pkg::APC_LN_IDLE;
               secs         <= 6'h0;
               ln_direct[g] <= 1'b0;
            end else if (ln_dis[g]) begin
               st <= apc_pkg::APC_LN_IDLE;
            end else if ((remote_reset || key_reset) && st == apc_pkg::APC_LN_FIRE) begin
               st   <= apc_pkg::APC_LN_RESETF;
               secs <= 6'h0;
            end else begin
               if (tick) secs <= secs + 6'h1;
               case (st)
                  apc_pkg::APC_LN_IDLE: begin
                     if (ln_test[g] && tick && sec_cnt == 6'h3f) begin
                        st   <= apc_pkg::APC_LN_RESETF;
                        secs <= 6'h0;
                     end else if (hit && sw == apc_pkg::SW_DIRECT) begin
                        st             <= apc_pkg::APC_LN_FIRE;
                        ln_direct[g]   <= 1'b1;
                        ln_new_fire[g] <= ~ln_test[g];
                     end else if (hit) begin
                        st   <= apc_pkg::APC_LN_RESET1;
                        secs <= 6'h0;
                     end
                  end
                  apc_pkg::APC_LN_RESET1:
                     if (tick && secs == 6'(apc_pkg::LINE_RESET_S - 1)) begin
                        st   <= apc_pkg::APC_LN_WAIT2;
                        secs <= 6'h0;
                     end
                  apc_pkg::APC_LN_WAIT2:
                     if (hit) begin
                        st             <= apc_pkg::APC_LN_FIRE;
                        ln_direct[g]   <= 1'b0;
                        ln_new_fire[g] <= ~ln_test[g];
                     end else if (tick && secs == 6'(apc_pkg::CONFIRM_S - 1))
                        st <= apc_pkg::APC_LN_IDLE;
                  apc_pkg::APC_LN_FIRE: ;
                  apc_pkg::APC_LN_RESETF:
                     if (tick && secs == 6'(apc_pkg::LINE_RESET_S - 1))
                        st <= apc_pkg::APC_LN_IDLE;
                  default: st <= apc_pkg::APC_LN_IDLE;
               endcase
            end
         end
         assign ln_fire[g]    = (st == apc_pkg::APC_LN_FIRE) & ~ln_test[g];
         assign ln_powered[g] = ~ln_dis[g] & (st != apc_pkg::APC_LN_RESET1) &
                                (st != apc_pkg::APC_LN_RESETF);
      end
   endgenerate
   assign o_line_power = ln_powered;

   // fire state and stage
   logic fire, stage2;
   assign fire   = |ln_fire;
   assign stage2 = |(ln_fire & ln_direct);

   // fault tracking with 8 s exit delay
   logic       fault_cause, fault_reg, fault_new;
   logic [3:0] clr_secs;
   logic [N_LINES-1:0] ln_fault_d;
   logic [8:0]         fsrc_d;
   assign fault_cause = (|fsrc) | (|ln_fault);
   assign fault_new   = (|(ln_fault & ~ln_fault_d)) | (|(fsrc & ~fsrc_d));
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         fault_reg     <= 1'b0;
         sys_fault_reg <= 1'b0;
         clr_secs      <= 4'h0;
         ln_fault_d    <= '0;
         fsrc_d        <= 9'h0;
      end else begin
         ln_fault_d <= ln_fault;
         fsrc_d     <= fsrc;
         if (fsrc[0]) sys_fault_reg <= 1'b1;
         if (fault_cause) begin
            fault_reg <= 1'b1;
            clr_secs  <= 4'h0;
         end else if (fault_reg && !sys_fault_reg && tick) begin
            if (clr_secs == 4'(apc_pkg::FAULT_EXIT_S - 1))
               fault_reg <= 1'b0;
            else
               clr_secs <= clr_secs + 4'h1;
         end
      end
   end

   // buzzer silence and output suppression toggles
   logic silenced, out_supp, duty_out, fire_d;
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         silenced <= 1'b0;
         out_supp <= 1'b0;
         duty_out <= 1'b0;
         fire_d   <= 1'b0;
      end else begin
         fire_d <= fire;
         if ((|ln_new_fire) || fault_new)
            silenced <= 1'b0;
         else if (p_buz && (fire || fault_reg))
            silenced <= ~silenced;
         else if (!fire && !fault_reg)
            silenced <= 1'b0;
         if (fire && p_out && key2)
            out_supp <= ~out_supp;
         else if (!fire)
            out_supp <= 1'b0;
         if (!fire && !fault_reg && p_out)
            duty_out <= ~duty_out;
         else if (remote_act)
            duty_out <= 1'b1;
      end
   end

   // line indicators with fault flash codes
   logic burst_ph;
   assign burst_ph = fast_ph & ~sec_cnt[0];                   // 1 s bursts, 1 s pause
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_line_red    <= '0;
         o_line_yellow <= '0;
      end else begin
         o_line_red <= ln_fire;
         for (int i = 0; i < N_LINES; i++) begin
            if (!ln_fault[i])
               o_line_yellow[i] <= ln_dis[i];
            else if (cls_s2[2*i+:2] == apc_pkg::CLS_SHORT)
               o_line_yellow[i] <= slow_ph;
            else if (cls_s2[2*i+:2] == apc_pkg::CLS_BREAK)
               o_line_yellow[i] <= fast_ph;
            else
               o_line_yellow[i] <= burst_ph;
         end
      end
   end

   // panel indicators, buzzer and relays
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_fire_state             <= 1'b0;
         o_fault_state            <= 1'b0;
         o_duty_mode              <= 1'b1;
         o_led_power              <= 1'b1;
         o_led_delay              <= 1'b0;
         o_led_fire               <= 1'b0;
         o_led_fault              <= 1'b0;
         o_led_buzzer_silenced    <= 1'b0;
         o_led_outputs_suppressed <= 1'b0;
         o_buzzer                 <= 1'b0;
         o_monitored_output_one   <= 1'b0;
         o_monitored_output_two   <= 1'b0;
         o_fire_relay_output      <= 1'b0;
         o_fault_relay_output     <= 1'b0;
      end else begin
         o_fire_state  <= fire;
         o_fault_state <= fault_reg;
         o_duty_mode   <= ~fire & ~fault_reg;
         o_led_power   <= 1'b1;
         o_led_delay   <= dly;
         o_led_fire    <= fire & (stage2 | slow_ph);
         o_led_fault   <= fault_reg & slow_ph;
         o_led_buzzer_silenced    <= silenced & (fire | fault_reg);
         o_led_outputs_suppressed <= fire & out_supp;
         // steady tone in fire, interrupted in fault, off in duty
         o_buzzer <= ~silenced & (fire | (fault_reg & slow_ph));
         o_monitored_output_one <= fire ? ~out_supp : duty_out;
         o_monitored_output_two <= fire ? ~out_supp : duty_out;
         o_fire_relay_output    <= fire & (mode_reg | ~out_supp);
         o_fault_relay_output   <= fault_reg;
      end
   end
endmodule
`default_nettype wire

// ===== tb/apc_ctrl_sva.sv
// concurrent checks on the alarm panel controller ports
`timescale 1ns/10ps
`default_nettype none
module apc_ctrl_sva #(
   parameter int N_LINES  = 8,
   parameter int TICK_CYC = 20
) (
   input wire logic                 i_clk_sys,
   input wire logic                 i_resetn,
   input wire logic [2*N_LINES-1:0] i_line_class,
   input wire logic [N_LINES-1:0]   i_line_removed,
   input wire logic [8:0]           i_fault_src,
   input wire logic                 i_mode_stored,
   input wire logic                 o_mode_store_we,
   input wire logic                 o_mode_store_val,
   input wire logic                 o_mode2,
   input wire logic                 o_fire_state,
   input wire logic                 o_fault_state,
   input wire logic                 o_duty_mode,
   input wire logic                 o_led_power,
   input wire logic                 o_led_fire,
   input wire logic                 o_led_buzzer_silenced,
   input wire logic                 o_buzzer,
   input wire logic                 o_fire_relay_output,
   input wire logic                 o_fault_relay_output
);
   logic        lf;
   logic [3:0]  sys_cnt;
   logic [15:0] q_cnt;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   // any line fault cause present
   always_comb begin
      lf = |i_line_removed;
      for (int i = 0; i < N_LINES; i++) lf |= i_line_class[2*i+1];
   end
   // cycles since a system fault, saturating
   always_ff @(posedge i_clk_sys)
      if (!i_resetn) sys_cnt <= 4'h0;
      else if ((sys_cnt != 4'h0 || i_fault_src[0]) && sys_cnt != 4'hf) sys_cnt <= sys_cnt + 4'h1;
   // cycles with no fault cause at all
   always_ff @(posedge i_clk_sys)
      if (!i_resetn || lf || |i_fault_src || sys_cnt != 4'h0) q_cnt <= 16'h0;
      else if (q_cnt != 16'hffff) q_cnt <= q_cnt + 16'h1;
   sequence s_store_pulse;
      (o_mode_store_val != i_mode_stored) ##1 !o_mode_store_we;
   endsequence
   property p_duty;
      $stable(o_fire_state || o_fault_state)[*2] |-> o_duty_mode == !(o_fire_state || o_fault_state);
   endproperty
   property p_quiet;
      o_duty_mode[*2] |-> !o_buzzer && !o_led_fire && o_led_power;
   endproperty
   property p_frel;
      $stable(o_fault_state)[*2] |-> o_fault_relay_output == o_fault_state;
   endproperty
   property p_sys;
      sys_cnt == 4'hf |-> o_fault_state && !o_mode_store_we;
   endproperty
   property p_early;
      q_cnt > 0 && q_cnt < 7*TICK_CYC && $past(o_fault_state) |-> o_fault_state;
   endproperty
   property p_late;
      q_cnt > 9*TICK_CYC + 8 |-> !o_fault_state;
   endproperty
   property p_buz;
      $rose(o_fire_state) |-> ##[0:3] o_buzzer;
   endproperty
   property p_store;
      o_mode_store_we |-> s_store_pulse;
   endproperty
   property p_m2rel;
      (o_mode2 && o_fire_state)[*4] |-> o_fire_relay_output;
   endproperty
   property p_sil;
      ((o_fire_state || o_fault_state) && o_led_buzzer_silenced)[*2] |-> !o_buzzer;
   endproperty
   a_duty: assert property (p_duty) else $error("duty flag wrong");
   a_quiet: assert property (p_quiet) else $error("duty indication wrong");
   a_frel: assert property (p_frel) else $error("fault relay wrong");
   a_sys: assert property (p_sys) else $error("system fault left");
   a_early: assert property (p_early) else $error("fault left early");
   a_late: assert property (p_late) else $error("fault kept too long");
   a_buz: assert property (p_buz) else $error("buzzer silent on fire");
   a_store: assert property (p_store) else $error("mode store write wrong");
   a_m2rel: assert property (p_m2rel) else $error("fire relay off in mode 2");
   a_sil: assert property (p_sil) else $error("silenced buzzer sounds");
endmodule
bind apc_ctrl apc_ctrl_sva #(.N_LINES(N_LINES), .TICK_CYC(TICK_CYC)) u_sva (.i_clk_sys, .i_resetn,
   .i_line_class, .i_line_removed, .i_fault_src, .i_mode_stored, .o_mode_store_we,
   .o_mode_store_val, .o_mode2, .o_fire_state, .o_fault_state, .o_duty_mode, .o_led_power,
   .o_led_fire, .o_led_buzzer_silenced, .o_buzzer, .o_fire_relay_output, .o_fault_relay_output);
`default_nettype wire

// ===== tb/apc_panel_model.sv
// far side model: detector lines and retained mode store
`timescale 1ns/10ps
`default_nettype none
module apc_panel_model #(
   parameter int N = 2
) (
   input  wire logic           i_clk_sys,
   input  wire logic [N-1:0]   i_power,
   input  wire logic [N-1:0]   i_trig,
   input  wire logic [2*N-1:0] i_fault,
   input  wire logic           i_we,
   input  wire logic           i_val,
   output logic [2*N-1:0]      o_class,
   output logic                o_stored
);
   logic [N-1:0] alarm_reg = '0;
   logic         store_reg = apc_pkg::MODE_RESET_VAL;
   // retained store survives panel restarts
   always_ff @(posedge i_clk_sys) if (i_we) store_reg <= i_val;
   assign o_stored = store_reg;
   // detector alarm latches until line power is cut
   always_ff @(posedge i_clk_sys) alarm_reg <= i_power & (alarm_reg | i_trig);
   // line current classification seen by the panel
   always_comb begin
      for (int i = 0; i < N; i++) begin
         o_class[2*i+:2] = (i_fault[2*i+:2] != 2'h0) ? i_fault[2*i+:2] :
                           (alarm_reg[i] & i_power[i]) ? apc_pkg::CLS_FIRE : apc_pkg::CLS_NORMAL;
      end
   end
endmodule
`default_nettype wire

// ===== tb/apc_ctrl_tb.sv
// self-checking bench for the alarm panel controller
`timescale 1ns/10ps
`default_nettype none
module apc_ctrl_tb;
   localparam int N = 2;
   localparam int T = 20;
   localparam int SH = 10;
   localparam int FH = 3;
   logic           clk, rstn, key, dly, we, wval, stored, mode2;
   logic [2*N-1:0] cls, sw, lflt;
   logic [N-1:0]   trig, pwr, red, yel, rmv;
   logic [3:0]     btn;
   logic [8:0]     fsrc;
   logic           fire, fault, duty, ledp, ledd, ledf, ledq, leds, ledo, buz, mo1, mo2, frel, qrel;
   int             num_errors, num_checks, nwe, k, m;
   apc_ctrl #(.N_LINES(N), .TICK_CYC(T), .SLOW_HALF(SH), .FAST_HALF(FH)) dut (
      .i_clk_sys(clk), .i_resetn(rstn), .i_line_class(cls), .i_line_switch(sw),
      .i_line_removed(rmv), .i_key_level2(key), .i_btn_reset(btn[0]), .i_btn_outputs(btn[1]),
      .i_btn_buzzer(btn[2]), .i_remote_fire_reset_input(btn[3]), .i_fault_src(fsrc),
      .i_delay_set(dly), .i_mode_stored(stored), .o_mode_store_we(we), .o_mode_store_val(wval),
      .o_mode2(mode2), .o_line_power(pwr), .o_line_red(red), .o_line_yellow(yel),
      .o_fire_state(fire), .o_fault_state(fault), .o_duty_mode(duty), .o_led_power(ledp),
      .o_led_delay(ledd), .o_led_fire(ledf), .o_led_fault(ledq), .o_led_buzzer_silenced(leds),
      .o_led_outputs_suppressed(ledo), .o_buzzer(buz), .o_monitored_output_one(mo1),
      .o_monitored_output_two(mo2), .o_fire_relay_output(frel), .o_fault_relay_output(qrel));
   apc_panel_model #(.N(N)) u_far (.i_clk_sys(clk), .i_power(pwr), .i_trig(trig),
      .i_fault(lflt), .i_we(we), .i_val(wval), .o_class(cls), .o_stored(stored));
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) if (we === 1'b1) nwe++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return fire;
         3: return yel[0];
         default: return pwr[0];
      endcase
   endfunction
   // bounded wait for a level, then compare it
   task automatic wait_for(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(s) !== v && n < lim) begin
         cyc(1);
         n++;
      end
      chk(pick(s), v);
   endtask
   task automatic press(input int b);
      btn[b] = 1'b1;
      cyc(6);
      btn[b] = 1'b0;
      cyc(6);
   endtask
   task automatic alarm(input int l);
      trig[l] = 1'b1;
      cyc(2);
      trig[l] = 1'b0;
   endtask
   // power cycle with key and reset button as given
   task automatic restart(input logic kv, input logic hold);
      rstn = 0;
      key = kv;
      btn[0] = hold;
      cyc(12);
      rstn = 1;
      cyc(30);
      btn[0] = 0;
      key = 0;
      cyc(4);
   endtask
   // measure one low half period of line 0 yellow
   task automatic half(output int n);
      wait_for(3, 1, 60);
      wait_for(3, 0, 60);
      n = 0;
      while (yel[0] === 1'b0 && n < 60) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      cyc(40000);
      num_errors++;
      report_and_stop;
   end
   initial begin
      {rstn, key, dly, btn, fsrc, sw, lflt, trig, rmv} = '0;
      restart(0, 0);
      chk({duty, ledp, mode2, buz, qrel, ledf}, 6'h30);
      dly = 1;
      cyc(6);
      chk({ledd, buz}, 2'h2);
      dly = 0;
      alarm(0);
      wait_for(4, 0, 400);
      k = 0;
      while (pwr[0] === 1'b0 && k < 4 * T) begin
         cyc(1);
         k++;
      end
      chk(k >= 2 * T && k <= 3 * T + 4 && fire === 1'b0, 1);
      alarm(0);
      wait_for(0, 1, 100);
      cyc(6);
      chk({red[0], buz, frel}, 3'h7);
      k = 0;
      repeat (4 * SH) begin
         cyc(1);
         k += ledf;
      end
      chk(k > 0 && k < 4 * SH, 1);
      $display("test done: line fire");
      press(2);
      chk({buz, leds}, 2'h1);
      sw[3:2] = apc_pkg::SW_DIRECT;
      cyc(4);
      alarm(1);
      cyc(40);
      chk({red[1], buz, ledf}, 3'h7);
      k = 0;
      repeat (4 * SH) begin
         cyc(1);
         k += ledf;
      end
      chk(k, 4 * SH);
      key = 1;
      press(1);
      chk({frel, ledo}, 2'h1);
      press(1);
      chk({frel, ledo}, 2'h2);
      key = 0;
      $display("test done: buzzer and outputs");
      fsrc[3] = 1;
      cyc(10);
      chk({fault, qrel, fire, duty}, 4'he);
      k = 0;
      repeat (2 * SH) begin
         cyc(1);
         k += ledq;
      end
      chk(k, SH);
      fsrc[3] = 0;
      cyc(6 * T);
      chk(fault, 1);
      cyc(4 * T);
      chk({fault, qrel}, 2'h0);
      press(0);
      chk(fire, 1);
      key = 1;
      press(0);
      chk({fire, pwr[0]}, 2'h0);
      key = 0;
      cyc(4 * T);
      $display("test done: fault and reset");
      press(1);
      chk({duty, mo1, mo2}, 3'h7);
      press(1);
      chk({mo1, mo2}, 2'h0);
      press(3);
      chk({mo1, mo2, fire}, 3'h6);
      lflt[1:0] = apc_pkg::CLS_SHORT;
      half(k);
      chk(k, SH);
      chk(fault, 1);
      lflt[1:0] = apc_pkg::CLS_BREAK;
      cyc(10);
      half(k);
      chk(k, FH);
      lflt = '0;
      // removed detector: longest dark run must be the one second pause
      rmv[0] = 1'b1;
      k = 0;
      m = 0;
      repeat (4 * T) begin
         cyc(1);
         m = (yel[0] === 1'b1) ? 0 : m + 1;
         if (m > k) k = m;
      end
      chk(k >= T && k < 2 * T, 1);
      rmv = '0;
      $display("test done: duty and line faults");
      restart(1, 1);
      chk({mode2, stored, 5'(nwe)}, 7'h61);
      restart(0, 0);
      chk({mode2, stored, 5'(nwe)}, 7'h61);
      // test line: periodic power cut, its fault hidden
      sw[1:0] = apc_pkg::SW_TEST;
      lflt[1:0] = apc_pkg::CLS_SHORT;
      wait_for(4, 0, 66 * T);
      chk({fault, yel[0]}, 2'h0);
      sw[1:0] = apc_pkg::SW_DUTY;
      lflt = '0;
      alarm(1);
      wait_for(0, 1, 100);
      key = 1;
      press(1);
      chk(frel, 1);
      key = 0;
      press(3);
      chk(fire, 0);
      $display("test done: mode two");
      fsrc[0] = 1;
      cyc(10);
      fsrc[0] = 0;
      press(2);
      chk(leds, 0);
      cyc(12 * T);
      chk(fault, 1);
      $display("test done: system fault");
      report_and_stop;
   end
endmodule
`default_nettype wire
